// ### core/gsrgr_pkg.sv
// Shared constants and types for the gas sensor readout link
package gsrgr_pkg;
   // ======================================================
   // Clock and times
   // ======================================================
   localparam int CLK_HZ    = 20_000_000;
   localparam int FIRST_MS  = 800;
   localparam int HIGH_US   = 16500;
   localparam int PERIOD_MS = 500;
   localparam int SETUP_MS  = 14;
   localparam int BAUD      = 9600;
   localparam int CHAR_BITS = 10;

   localparam logic [24:0] FIRST_CYC  = 25'(CLK_HZ / 1000 * FIRST_MS);
   localparam logic [24:0] HIGH_CYC   = 25'(CLK_HZ / 1000000 * HIGH_US);
   localparam logic [24:0] PERIOD_CYC = 25'(CLK_HZ / 1000 * PERIOD_MS);
   localparam logic [24:0] SETUP_CYC  = 25'(CLK_HZ / 1000 * SETUP_MS);
   localparam logic [11:0] BAUD_CYC   = 12'(CLK_HZ / BAUD);
   localparam logic [3:0]  CHAR_TICKS = 4'(CHAR_BITS);

   // ======================================================
   // Sensor register indices on the link
   // ======================================================
   localparam logic [3:0] REG_FILT_OUT = 4'h0;
   localparam logic [3:0] REG_RAW_OUT  = 4'h1;
   localparam logic [3:0] REG_FILTER   = 4'h2;
   localparam logic [3:0] REG_REF_PPM  = 4'h3;
   localparam logic [3:0] REG_ZERO_CMD = 4'h4;
   localparam logic [3:0] REG_STATUS   = 4'h5;

   localparam logic [15:0] CMD_ZERO_N2  = 16'h0001;
   localparam logic [15:0] CMD_ZERO_GAS = 16'h0002;
   localparam logic [7:0]  FILTER_RST   = 8'h10;
   localparam logic [15:0] REF_RST      = 16'h0000;
   localparam logic [15:0] ZERO_RST     = 16'h0000;

   // ======================================================
   // Host Wishbone map
   // ======================================================
   localparam logic [7:0] WB_CMD    = 8'h00;
   localparam logic [7:0] WB_STATUS = 8'h04;
   localparam logic [7:0] WB_RDATA  = 8'h08;
   localparam int CMD_ADDR_LSB = 16;
   localparam int CMD_WE_BIT   = 20;

   typedef enum {DEV_WARM, DEV_DIV, DEV_HIGH, DEV_LOW} gsrgr_dev_st_t;
   typedef enum {H_IDLE, H_WAIT, H_BUSY} gsrgr_host_st_t;
endpackage

// ### core/gsrgr_link_if.sv
// Link between the sensor end and the host end
`timescale 1ns/10ps
interface gsrgr_link_if;
   logic        ready;
   logic        i2c_sel_n;
   logic        req_valid;
   logic        req_we;
   logic [3:0]  req_addr;
   logic [15:0] req_wdata;
   logic        rsp_valid;
   logic [15:0] rsp_rdata;

   modport dev (
      output ready, rsp_valid, rsp_rdata,
      input  i2c_sel_n, req_valid, req_we, req_addr, req_wdata
   );
   modport hst (
      input  ready, rsp_valid, rsp_rdata,
      output i2c_sel_n, req_valid, req_we, req_addr, req_wdata
   );
endinterface

// ### core/gsrgr_div.sv
// Sequential restoring divider for the filter update
`timescale 1ns/10ps
module gsrgr_div (
   input  wire logic        CLOCK,
   input  wire logic        NRST,
   input  wire logic        START,
   input  wire logic [24:0] DIVIDEND,
   input  wire logic [7:0]  DIVISOR,
   output logic             DONE,
   output logic [24:0]      QUOT
);
   logic [24:0] quot_q;
   logic [8:0]  rem_q;
   logic [4:0]  cnt_q;
   logic        busy_q;
   logic        done_q;
   logic [9:0]  trial;

   // One quotient bit per cycle; slow but tiny, and time is plentiful
   assign trial = {1'b0, rem_q[7:0], quot_q[24]} - {2'h0, DIVISOR};
   assign DONE  = done_q;
   assign QUOT  = quot_q;

   always_ff @(posedge CLOCK) begin
      if (!NRST) begin
         quot_q <= 25'h000_0000;
         rem_q  <= 9'h000;
         cnt_q  <= 5'h00;
         busy_q <= 1'b0;
         done_q <= 1'b0;
      end else begin
         done_q <= 1'b0;
         if (START) begin
            quot_q <= DIVIDEND;
            rem_q  <= 9'h000;
            cnt_q  <= 5'h19;
            busy_q <= 1'b1;
         end else if (busy_q) begin
            if (trial[9]) begin
               rem_q <= {rem_q[7:0], quot_q[24]};
            end else begin
               rem_q <= trial[8:0];
            end
            quot_q <= {quot_q[23:0], ~trial[9]};
            cnt_q  <= cnt_q - 5'h01;
            if (cnt_q == 5'h01) begin
               busy_q <= 1'b0;
               done_q <= 1'b1;
            end
         end
      end
   end
endmodule

// ### core/gsrgr_dev.sv
// Sensor end: measurement sequencing, ready gating and readout
//
// The register addresses and the Wishbone interface to the registers are this design's own decisions.
`timescale 1ns/10ps
module gsrgr_dev #(
   parameter logic [24:0] P_FIRST  = gsrgr_pkg::FIRST_CYC,
   parameter logic [24:0] P_HIGH   = gsrgr_pkg::HIGH_CYC,
   parameter logic [24:0] P_PERIOD = gsrgr_pkg::PERIOD_CYC
) (
   input  wire logic        CLOCK,
   input  wire logic        NRST,
   gsrgr_link_if.dev        LINK,
   input  wire logic [15:0] RAW_SAMPLE,
   output logic             SAMPLE_STB,
   output logic             MODE_I2C,
   output logic             RESULT_VALID
);
   import gsrgr_pkg::*;

   gsrgr_dev_st_t st_q;
   logic [24:0]   tmr_q;
   logic [24:0]   hi_q;
   logic [7:0]    warm_q;
   logic          ready_q;
   logic          served_q;
   logic          sample_q;
   logic          div_start_q;
   logic          mode_done_q;
   logic          mode_i2c_q;
   logic [7:0]    filter_q;
   logic [15:0]   ref_q;
   logic [15:0]   zero_q;
   logic [15:0]   corr_q;
   logic [15:0]   acc_q;
   logic [15:0]   filt_out_q;
   logic [15:0]   raw_out_q;
   logic          rsp_valid_q;
   logic [15:0]   rsp_data_q;
   logic          uart_busy_q;
   logic [11:0]   baud_q;
   logic [3:0]    ticks_q;
   logic          meas;
   logic          accept;
   logic          baud_tick;
   logic [23:0]   prod;
   logic [24:0]   dividend;
   logic          div_done;
   logic [24:0]   div_quot;

   // Clamp at zero so a zero above the reading cannot wrap
   function automatic logic [15:0] sat_sub(input logic [15:0] a,
                                           input logic [15:0] b);
      sat_sub = (a > b) ? (a - b) : 16'h0000;
   endfunction

   function automatic logic [15:0] read_mux(input logic [3:0] adr);
      read_mux = 16'h0000;
      case (adr)
         REG_FILT_OUT: read_mux = filt_out_q;
         REG_RAW_OUT:  read_mux = raw_out_q;
         REG_FILTER:   read_mux = {8'h00, filter_q};
         REG_REF_PPM:  read_mux = ref_q;
         REG_STATUS:   read_mux = {14'h0000, served_q, mode_i2c_q};
         default:      read_mux = 16'h0000;
      endcase
   endfunction

   assign LINK.ready     = ready_q;
   assign LINK.rsp_valid = rsp_valid_q;
   assign LINK.rsp_rdata = rsp_data_q;
   assign SAMPLE_STB     = sample_q;
   assign MODE_I2C       = mode_i2c_q;
   assign RESULT_VALID   = served_q;

   // ======================================================
   // Interface strap
   // ======================================================
   // Caught at the first edge after release, never again
   always_ff @(posedge CLOCK) begin
      if (!NRST) begin
         mode_done_q <= 1'b0;
         mode_i2c_q  <= 1'b0;
      end else if (!mode_done_q) begin
         mode_done_q <= 1'b1;
         mode_i2c_q  <= ~LINK.i2c_sel_n;
      end
   end

   // ======================================================
   // Measurement sequencer
   // ======================================================
   // First start after warm-up, then one per period
   assign meas = (st_q == DEV_WARM) ? (tmr_q == P_FIRST - 25'h000_0001)
                                    : (tmr_q == P_PERIOD - 25'h000_0001);

   always_ff @(posedge CLOCK) begin
      if (!NRST) begin
         st_q        <= DEV_WARM;
         tmr_q       <= 25'h000_0000;
         hi_q        <= 25'h000_0000;
         warm_q      <= FILTER_RST - 8'h01;
         ready_q     <= 1'b0;
         served_q    <= 1'b0;
         sample_q    <= 1'b0;
         div_start_q <= 1'b0;
      end else begin
         sample_q    <= 1'b0;
         div_start_q <= sample_q;
         tmr_q       <= meas ? 25'h000_0000 : tmr_q + 25'h000_0001;
         if (meas) begin
            st_q     <= DEV_DIV;
            sample_q <= 1'b1;
            ready_q  <= 1'b0;
         end else begin
            case (st_q)
               DEV_WARM: begin
                  ready_q <= 1'b0;
               end
               DEV_DIV: begin
                  if (div_done) begin
                     // Early results only settle the filter
                     if (warm_q == 8'h00) begin
                        ready_q <= 1'b1;
                        hi_q    <= 25'h000_0000;
                        st_q    <= DEV_HIGH;
                     end else begin
                        warm_q <= warm_q - 8'h01;
                        st_q   <= DEV_LOW;
                     end
                  end
               end
               DEV_HIGH: begin
                  if (hi_q == P_HIGH - 25'h000_0001) begin
                     ready_q  <= 1'b0;
                     served_q <= 1'b1;
                     st_q     <= DEV_LOW;
                  end else begin
                     hi_q <= hi_q + 25'h000_0001;
                  end
               end
               DEV_LOW: begin
                  ready_q <= 1'b0;
               end
               default: begin
                  st_q    <= DEV_WARM;
                  ready_q <= 1'b0;
               end
            endcase
         end
      end
   end

   // ======================================================
   // Zero correction and filter
   // ======================================================
   // acc = (acc * (N - 1) + sample) / N; N = 1 is a pass-through
   assign prod     = acc_q * (filter_q - 8'h01);
   assign dividend = {1'b0, prod} + {9'h000, corr_q};

   gsrgr_div u_div (
      .CLOCK    (CLOCK),
      .NRST     (NRST),
      .START    (div_start_q),
      .DIVIDEND (dividend),
      .DIVISOR  (filter_q),
      .DONE     (div_done),
      .QUOT     (div_quot)
   );

   always_ff @(posedge CLOCK) begin
      if (!NRST) begin
         corr_q     <= 16'h0000;
         acc_q      <= 16'h0000;
         filt_out_q <= 16'h0000;
         raw_out_q  <= 16'h0000;
      end else begin
         if (meas) begin
            corr_q <= sat_sub(RAW_SAMPLE, zero_q);
         end
         if (div_done) begin
            acc_q <= div_quot[15:0];
         end
         // Published copies change only when a pulse starts
         if (div_done && st_q == DEV_DIV && warm_q == 8'h00) begin
            filt_out_q <= div_quot[15:0];
            raw_out_q  <= corr_q;
         end
      end
   end

   // ======================================================
   // Link requests and configuration
   // ======================================================
   assign accept = LINK.req_valid & ~ready_q & served_q
                   & ~uart_busy_q & mode_done_q;

   always_ff @(posedge CLOCK) begin
      if (!NRST) begin
         filter_q <= FILTER_RST;
         ref_q    <= REF_RST;
         zero_q   <= ZERO_RST;
      end else if (accept && LINK.req_we) begin
         case (LINK.req_addr)
            REG_FILTER: begin
               if (LINK.req_wdata != 16'h0000 &&
                   LINK.req_wdata[15:8] == 8'h00) begin
                  filter_q <= LINK.req_wdata[7:0];
               end
            end
            REG_REF_PPM: begin
               ref_q <= LINK.req_wdata;
            end
            REG_ZERO_CMD: begin
               // Single slot, overwritten by any method
               if (LINK.req_wdata == CMD_ZERO_N2) begin
                  zero_q <= RAW_SAMPLE;
               end else if (LINK.req_wdata == CMD_ZERO_GAS) begin
                  zero_q <= sat_sub(RAW_SAMPLE, ref_q);
               end
            end
            default: begin
               zero_q <= zero_q;
            end
         endcase
      end
   end

   // ======================================================
   // Answer timing: I2C next cycle, UART after one character
   // ======================================================
   assign baud_tick = (baud_q == BAUD_CYC - 12'h001);

   always_ff @(posedge CLOCK) begin
      if (!NRST) begin
         baud_q <= 12'h000;
      end else begin
         baud_q <= baud_tick ? 12'h000 : baud_q + 12'h001;
      end
   end

   always_ff @(posedge CLOCK) begin
      if (!NRST) begin
         rsp_valid_q <= 1'b0;
         rsp_data_q  <= 16'h0000;
         uart_busy_q <= 1'b0;
         ticks_q     <= 4'h0;
      end else begin
         rsp_valid_q <= 1'b0;
         if (accept) begin
            rsp_data_q <= LINK.req_we ? 16'h0000
                                      : read_mux(LINK.req_addr);
            if (mode_i2c_q) begin
               rsp_valid_q <= 1'b1;
            end else begin
               uart_busy_q <= 1'b1;
               ticks_q     <= 4'h0;
            end
         end else if (uart_busy_q && baud_tick) begin
            if (ticks_q == CHAR_TICKS - 4'h1) begin
               uart_busy_q <= 1'b0;
               rsp_valid_q <= 1'b1;
            end else begin
               ticks_q <= ticks_q + 4'h1;
            end
         end
      end
   end
endmodule

// ### core/gsrgr_host.sv
// Host end: Wishbone command registers driving the sensor link
`timescale 1ns/10ps
module gsrgr_host #(
   parameter logic [24:0] P_SETUP = gsrgr_pkg::SETUP_CYC
) (
   input  wire logic        CLOCK,
   input  wire logic        NRST,
   gsrgr_link_if.hst        LINK,
   input  wire logic        I2C_SEL_N,
   input  wire logic        WB_CYC,
   input  wire logic        WB_STB,
   input  wire logic        WB_WE,
   input  wire logic [7:0]  WB_ADR,
   input  wire logic [3:0]  WB_SEL,
   input  wire logic [31:0] WB_DAT_I,
   output logic [31:0]      WB_DAT_O,
   output logic             WB_ACK
);
   import gsrgr_pkg::*;

   gsrgr_host_st_t st_q;
   logic           ack_q;
   logic [31:0]    dat_q;
   logic           sel_q;
   logic           rdy_d1_q;
   logic           armed_q;
   logic           open_q;
   logic [24:0]    setup_q;
   logic           we_q;
   logic [3:0]     addr_q;
   logic [15:0]    wdata_q;
   logic [15:0]    rdata_q;
   logic           req_q;
   logic           done_q;
   logic           abort_q;
   logic           refused_q;
   logic           ref_ok_q;
   logic           wb_go;
   logic           gas_cmd;

   assign LINK.i2c_sel_n = sel_q;
   assign LINK.req_valid = req_q;
   assign LINK.req_we    = we_q;
   assign LINK.req_addr  = addr_q;
   assign LINK.req_wdata = wdata_q;
   assign WB_DAT_O       = dat_q;
   assign WB_ACK         = ack_q;

   // Command acts at the edge where the master samples ack
   assign wb_go   = WB_CYC & WB_STB & WB_WE & ack_q & (WB_ADR == WB_CMD)
                    & (WB_SEL[2:0] == 3'h7);
   assign gas_cmd = WB_DAT_I[CMD_WE_BIT]
                    & (WB_DAT_I[CMD_ADDR_LSB +: 4] == REG_ZERO_CMD)
                    & (WB_DAT_I[15:0] == CMD_ZERO_GAS);

   // Strap level follows the pin so it is valid at release
   always_ff @(posedge CLOCK) begin
      sel_q <= I2C_SEL_N;
   end

   // ======================================================
   // Wishbone slave
   // ======================================================
   always_ff @(posedge CLOCK) begin
      if (!NRST) begin
         ack_q <= 1'b0;
         dat_q <= 32'h0000_0000;
      end else begin
         ack_q <= WB_CYC & WB_STB & ~ack_q;
         case (WB_ADR)
            WB_CMD:    dat_q <= {11'h000, we_q, addr_q, wdata_q};
            WB_STATUS: dat_q <= {27'h000_0000, refused_q, abort_q,
                                 done_q, open_q, st_q != H_IDLE};
            WB_RDATA:  dat_q <= {16'h0000, rdata_q};
            default:   dat_q <= 32'h0000_0000;
         endcase
      end
   end

   // ======================================================
   // Access window after each ready pulse
   // ======================================================
   always_ff @(posedge CLOCK) begin
      if (!NRST) begin
         rdy_d1_q <= 1'b0;
         armed_q  <= 1'b0;
         open_q   <= 1'b0;
         setup_q  <= 25'h000_0000;
      end else begin
         rdy_d1_q <= LINK.ready;
         if (LINK.ready) begin
            open_q  <= 1'b0;
            armed_q <= 1'b0;
         end else if (rdy_d1_q) begin
            armed_q <= 1'b1;
            setup_q <= 25'h000_0000;
         end else if (armed_q) begin
            if (setup_q == P_SETUP - 25'h000_0001) begin
               open_q  <= 1'b1;
               armed_q <= 1'b0;
            end else begin
               setup_q <= setup_q + 25'h000_0001;
            end
         end
      end
   end

   // ======================================================
   // Transaction sequencer
   // ======================================================
   always_ff @(posedge CLOCK) begin
      if (!NRST) begin
         st_q      <= H_IDLE;
         we_q      <= 1'b0;
         addr_q    <= 4'h0;
         wdata_q   <= 16'h0000;
         rdata_q   <= 16'h0000;
         req_q     <= 1'b0;
         done_q    <= 1'b0;
         abort_q   <= 1'b0;
         refused_q <= 1'b0;
         ref_ok_q  <= 1'b0;
      end else begin
         req_q <= 1'b0;
         case (st_q)
            H_IDLE: begin
               if (wb_go) begin
                  we_q      <= WB_DAT_I[CMD_WE_BIT];
                  addr_q    <= WB_DAT_I[CMD_ADDR_LSB +: 4];
                  wdata_q   <= WB_DAT_I[15:0];
                  done_q    <= 1'b0;
                  abort_q   <= 1'b0;
                  refused_q <= gas_cmd & ~ref_ok_q;
                  if (!(gas_cmd && !ref_ok_q)) begin
                     st_q <= H_WAIT;
                  end
               end
            end
            H_WAIT: begin
               if (open_q && !LINK.ready) begin
                  req_q <= 1'b1;
                  st_q  <= H_BUSY;
               end
            end
            H_BUSY: begin
               if (LINK.rsp_valid) begin
                  rdata_q <= LINK.rsp_rdata;
                  done_q  <= 1'b1;
                  st_q    <= H_IDLE;
                  if (we_q && addr_q == REG_REF_PPM) begin
                     ref_ok_q <= 1'b1;
                  end
               end else if (LINK.ready) begin
                  abort_q <= 1'b1;
                  st_q    <= H_IDLE;
               end
            end
            default: begin
               st_q <= H_IDLE;
            end
         endcase
      end
   end
endmodule

// ### tb/gsrgr_asserts.sv
// Link checker for the sensor and host ends
`timescale 1ns/10ps
module gsrgr_asserts #(
   parameter int P_FIRST  = 2000,
   parameter int P_HIGH   = 200,
   parameter int P_PERIOD = 3000,
   parameter int P_SETUP  = 50
) (
   input wire logic        CLOCK,
   input wire logic        NRST,
   input wire logic        ready,
   input wire logic        i2c_sel_n,
   input wire logic        req_valid,
   input wire logic        req_we,
   input wire logic [3:0]  req_addr,
   input wire logic [15:0] req_wdata,
   input wire logic        rsp_valid,
   input wire logic [15:0] rsp_rdata
);
   logic [24:0] hi_q, per_q, lo_q, up_q;
   logic        rdy_q, seen_q;
   // ======================================================
   // Counters
   // ======================================================
   always_ff @(posedge CLOCK) begin
      hi_q <= (NRST && ready) ? hi_q + 1'b1 : '0;
   end
   always_ff @(posedge CLOCK) begin
      lo_q <= (NRST && !ready) ? lo_q + 1'b1 : '0;
   end
   always_ff @(posedge CLOCK) begin
      up_q <= NRST ? up_q + 1'b1 : '0;
   end
   always_ff @(posedge CLOCK) begin
      rdy_q <= NRST && ready;
   end
   // Period counter restarts on every rising edge of ready
   always_ff @(posedge CLOCK) begin
      per_q <= !NRST ? '0 : (ready && !rdy_q) ? 25'h000_0001
                                             : per_q + 1'b1;
   end
   always_ff @(posedge CLOCK) begin
      seen_q <= NRST && (seen_q || (ready && !rdy_q));
   end
   // ======================================================
   // Properties
   // ======================================================
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (!NRST);
   chk_ready_width: assert property (
      $fell(ready) |-> hi_q == P_HIGH) else $error("ready width");
   chk_ready_bounded: assert property (
      ready |-> hi_q < P_HIGH) else $error("ready too long");
   chk_pulse_period: assert property (
      $rose(ready) && seen_q |-> per_q == P_PERIOD) else $error("period");
   chk_first_pulse: assert property (
      $rose(ready) && !seen_q |-> up_q >= P_FIRST) else $error("early");
   chk_ready_start: assert property (
      up_q < 4 |-> !ready) else $error("ready at start");
   // Only the I2C answer follows its request by one cycle
   chk_gate_ready: assert property (
      rsp_valid && !i2c_sel_n |-> $past(req_valid) && !$past(ready))
      else $error("gate");
   chk_req_low: assert property (
      req_valid |-> !ready) else $error("request while ready");
   chk_setup_gap: assert property (
      req_valid |-> lo_q >= P_SETUP) else $error("setup gap");
   // Data moves only at an accept, in either mode
   chk_rdata_hold: assert property (
      $changed(rsp_rdata) |-> $past(req_valid)) else $error("rdata moved");
   cov_pulse: cover property ($rose(ready));
   cov_read: cover property (rsp_valid && !req_we);
   cov_write: cover property (req_valid && req_we);
endmodule

// ### tb/tb.sv
// Testbench: both link ends against a behavioural result model
`timescale 1ns/10ps
module tb;
   import gsrgr_pkg::*;
   localparam int PF = 2000, PH = 200, PP = 3000, PS = 50;
   logic        CLOCK = 0, NRST = 0, sel_n = 0, cyc = 0, stb_w = 0;
   logic        we = 0, rdy_d = 0, ack, smp, mi2c, rv;
   logic [7:0]  adr = '0;
   logic [3:0]  sel = 4'hf;
   logic [31:0] dat = '0, dat_o, st, q;
   logic [15:0] raw, r;
   int mismatches = 0, checks = 0, nf = 16, acc = 0, lc = 0, zero = 0;
   int pf, pr, c, seed = 32'hd073_84b2;
   int fv[4] = '{0, 255, 1, 256};
   int fe[4] = '{16, 255, 1, 1};
   gsrgr_link_if lnk ();
   gsrgr_dev #(.P_FIRST(25'(PF)), .P_HIGH(25'(PH)), .P_PERIOD(25'(PP)))
   i_gsrgr_dev (.CLOCK(CLOCK), .NRST(NRST), .LINK(lnk), .RAW_SAMPLE(raw),
      .SAMPLE_STB(smp), .MODE_I2C(mi2c), .RESULT_VALID(rv));
   gsrgr_host #(.P_SETUP(25'(PS))) i_gsrgr_host (.CLOCK(CLOCK),
      .NRST(NRST), .LINK(lnk), .I2C_SEL_N(sel_n), .WB_CYC(cyc),
      .WB_STB(stb_w), .WB_WE(we), .WB_ADR(adr), .WB_SEL(sel),
      .WB_DAT_I(dat), .WB_DAT_O(dat_o), .WB_ACK(ack));
   gsrgr_asserts #(.P_FIRST(PF), .P_HIGH(PH), .P_PERIOD(PP), .P_SETUP(PS))
   i_gsrgr_asserts (.CLOCK(CLOCK), .NRST(NRST), .ready(lnk.ready),
      .i2c_sel_n(lnk.i2c_sel_n), .req_valid(lnk.req_valid),
      .req_we(lnk.req_we), .req_addr(lnk.req_addr),
      .req_wdata(lnk.req_wdata), .rsp_valid(lnk.rsp_valid),
      .rsp_rdata(lnk.rsp_rdata));
   initial forever #25 CLOCK = ~CLOCK;
   // ======================================================
   // Result model; raw input moves only in reset and after a publish
   // ======================================================
   always @(posedge CLOCK) begin
      if (NRST !== 1'b1) begin
         raw <= 16'($random(seed));
      end
      if (smp === 1'b1) begin
         c = raw > zero ? raw - zero : 0;
         acc = (acc * (nf - 1) + c) / nf;
         lc = c;
      end
      if (lnk.ready === 1'b1 && !rdy_d) begin
         pf = acc;
         pr = lc;
         raw <= 16'($random(seed));
      end
      rdy_d = lnk.ready;
   end
   task automatic chk(input string nm, input logic [31:0] s, e);
      checks++;
      if (s !== e) begin
         mismatches++;
         $display("mismatch %s exp %h seen %h", nm, e, s);
      end
   endtask
   task automatic wb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
      @(posedge CLOCK);
      cyc <= 1;
      stb_w <= 1;
      we <= w;
      adr <= a;
      dat <= d;
      do @(posedge CLOCK); while (ack !== 1'b1);
      q = dat_o;
      cyc <= 0;
      stb_w <= 0;
   endtask
   // Launch one link transfer and wait for its outcome
   task automatic op(input logic w, input logic [3:0] i,
                     input logic [15:0] d);
      wb(1, WB_CMD, {11'h0, w, i, d});
      do wb(0, WB_STATUS, '0); while (q[4:2] === 3'b000);
      st = q;
      wb(0, WB_RDATA, '0);
      r = q[15:0];
   endtask
   task automatic finish_test;
      if (mismatches == 0 && checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   initial begin
      #5_000_000;
      mismatches++;
      finish_test;
   end
   initial begin
      repeat (2) @(posedge CLOCK);
      NRST <= 1;
      @(posedge CLOCK);
      chk("valid", rv, 0);
      op(1, REG_ZERO_CMD, CMD_ZERO_GAS);
      chk("refused", st[4], 1);
      op(0, REG_STATUS, '0);
      chk("status", r, 3);
      chk("valid", rv, 1);
      op(0, REG_FILT_OUT, '0);
      chk("filt", r, pf);
      op(0, REG_FILT_OUT, '0);
      chk("filt", r, pf);
      op(0, REG_RAW_OUT, '0);
      chk("raw", r, pr);
      foreach (fv[k]) begin
         op(1, REG_FILTER, 16'(fv[k]));
         op(0, REG_FILTER, '0);
         chk("filter", r, fe[k]);
      end
      nf = 1;
      repeat (2) @(posedge lnk.ready);
      op(0, REG_FILT_OUT, '0);
      chk("filt", r, pf);
      op(1, REG_ZERO_CMD, CMD_ZERO_N2);
      zero = raw;
      @(posedge lnk.ready);
      op(0, REG_RAW_OUT, '0);
      chk("raw", r, pr);
      chk("raw zero", r, 0);
      op(1, REG_REF_PPM, 16'h0100);
      op(1, REG_ZERO_CMD, CMD_ZERO_GAS);
      chk("refused", st[4], 0);
      zero = raw > 'h100 ? raw - 'h100 : 0;
      @(posedge lnk.ready);
      op(0, REG_RAW_OUT, '0);
      chk("raw", r, pr);
      sel_n <= 1;
      @(posedge lnk.ready);
      chk("mode", mi2c, 1);
      sel_n <= 0;
      sel <= 4'h1;
      wb(1, WB_CMD, {11'h0, 1'b0, REG_STATUS, 16'h0});
      sel <= 4'hf;
      wb(0, WB_STATUS, '0);
      chk("busy", q[0], 0);
      wb(0, 8'h0c, '0);
      chk("unmapped", q, 0);
      finish_test;
   end
endmodule
